// >>> rtl/cwb_top.sv
// Top of the beamformer: pin sync, serial engine and wave generators
`timescale 1ns/10ps
module cwb_top
	import cwb_pkg::*;
(
	input wire logic clk, // Transmit clock
	input wire logic resetn, // Async reset, low
	input wire logic enable, // Chip enable, low clears registers
	input wire logic select_low, // Serial select, low
	input wire logic sck, // Serial clock pin
	input wire logic sdi, // Serial data in
	input wire logic broadcast_select, // 1 broadcast, 0 chain
	input wire logic transmit_run, // Start transmission
	output logic sdo, // Serial data out
	output logic [NUM_CH-1:0] wave_out, // Level, 1 positive
	output logic [NUM_CH-1:0] wave_oe // High while channel drives
);
	logic [1:0] sel_s_r, sck_s_r, sdi_s_r, en_s_r, bc_s_r, run_s_r;
	logic sdo_chain, sdo_nxt;
	logic [NUM_CH*DATA_BITS-1:0] delays;
	logic [DATA_BITS-1:0] float_bits, divisor;
	cwb_sync_if sp ();

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sel_s_r <= 2'h3;
			sck_s_r <= 2'h0;
			sdi_s_r <= 2'h0;
			en_s_r <= 2'h0;
			bc_s_r <= 2'h0;
			run_s_r <= 2'h0;
		end else begin
			sel_s_r <= {sel_s_r[0], select_low};
			sck_s_r <= {sck_s_r[0], sck};
			sdi_s_r <= {sdi_s_r[0], sdi};
			en_s_r <= {en_s_r[0], enable};
			bc_s_r <= {bc_s_r[0], broadcast_select};
			run_s_r <= {run_s_r[0], transmit_run};
		end
	end

	assign sp.sel_low = sel_s_r[1];
	assign sp.sck = sck_s_r[1];
	assign sp.sdi = sdi_s_r[1];

	cwb_serial u_serial (
		.clk(clk),
		.resetn(resetn),
		.enable(en_s_r[1]),
		.broadcast_select(bc_s_r[1]),
		.pins(sp),
		.phase_delay_value(delays),
		.output_float_bits(float_bits),
		.tone_freq_divisor(divisor),
		.sdo_r(sdo_chain)
	);

	// Broadcast passes data through the sync stages and output flop, three clocks in all
	assign sdo_nxt = bc_s_r[1] ? sdi_s_r[1] : sdo_chain; // RL7

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sdo <= 1'b0;
		end else begin
			sdo <= sdo_nxt;
		end
	end

	// Divisor zero behaves as 256 half-period cycles
	function automatic logic [8:0] half_period(input logic [7:0] d);
		return (d == REG_RESET) ? DIV_ZERO_HALF : {1'b0, d}; // RL21
	endfunction : half_period

	localparam logic [1:0] LAT_LAST = 2'(RUN_LATENCY - 1);
	cwb_ch_e st_r [NUM_CH];
	cwb_ch_e st_nxt [NUM_CH];
	logic [8:0] cnt_r [NUM_CH];
	logic [8:0] cnt_nxt [NUM_CH];
	logic [1:0] lat_r, lat_nxt;
	logic [NUM_CH-1:0] out_nxt, oe_nxt;
	logic run;

	assign run = run_s_r[1] & en_s_r[1];

	always_comb begin
		lat_nxt = lat_r;
		out_nxt = wave_out;
		oe_nxt = wave_oe;
		for (int c = 0; c < NUM_CH; c++) begin
			st_nxt[c] = st_r[c];
			cnt_nxt[c] = cnt_r[c];
			if (!run) begin
				st_nxt[c] = CWB_IDLE;
				oe_nxt[c] = 1'b0; // RL19
				out_nxt[c] = 1'b0;
			end else begin
				case (st_r[c])
					CWB_IDLE: begin
						if (!float_bits[c]) begin // RL20
							st_nxt[c] = CWB_WAIT;
						end
					end
					CWB_WAIT: begin
						if (lat_r == LAT_LAST) begin // RL16
							st_nxt[c] = CWB_COUNT;
							cnt_nxt[c] = {1'b0, delays[c*DATA_BITS +: DATA_BITS]};
						end
					end
					CWB_COUNT: begin
						if (cnt_r[c] == 9'h000) begin
							st_nxt[c] = CWB_WAVE;
							out_nxt[c] = 1'b1; // RL17
							oe_nxt[c] = 1'b1;
							cnt_nxt[c] = half_period(divisor) - 9'h001;
						end else begin
							cnt_nxt[c] = cnt_r[c] - 9'h001;
						end
					end
					CWB_WAVE: begin
						if (cnt_r[c] == 9'h000) begin
							out_nxt[c] = ~wave_out[c]; // RL18
							cnt_nxt[c] = half_period(divisor) - 9'h001;
						end else begin
							cnt_nxt[c] = cnt_r[c] - 9'h001;
						end
					end
					default: st_nxt[c] = CWB_IDLE;
				endcase
			end
		end
		if (!run) begin
			lat_nxt = 2'h0;
		end else if (lat_r != LAT_LAST) begin
			lat_nxt = lat_r + 2'h1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lat_r <= 2'h0;
			wave_out <= '0;
			wave_oe <= '0;
			for (int c = 0; c < NUM_CH; c++) begin
				st_r[c] <= CWB_IDLE;
				cnt_r[c] <= 9'h000;
			end
		end else begin
			lat_r <= lat_nxt;
			wave_out <= out_nxt;
			wave_oe <= oe_nxt;
			for (int c = 0; c < NUM_CH; c++) begin
				st_r[c] <= st_nxt[c];
				cnt_r[c] <= cnt_nxt[c];
			end
		end
	end
endmodule : cwb_top

// >>> rtl/cwb_pkg.sv
// Constants and types shared by the beamformer serial and timing logic
// Operation
// [RL1] Host lowers select before serial clocks
// [RL2] Frame: write bit, address, data, MSB first
// [RL3] Sample input on serial clock rise while selected
// [RL4] Write lands at select rising edge
// [RL5] Host holds select high two serial clocks
// [RL6] Chain needs thirteen clocks per chip
// [RL7] Broadcast routes serial input to output
// [RL8] Broadcast loads same register in every chip
// [RL9] Read frame has write bit zero
// [RL10] Read fetch loads shifter while deselected
// [RL11] Next frame shifts fetched data out
// [RL12] No reads while broadcast selected
// [RL13] Address 0011b is channel three delay
// [RL14] Host raises enable before use
// [RL15] Host programs before raising transmit run
// [RL16] Delay countdown starts two clocks after run
// [RL17] Count zero drives positive next edge
// [RL18] Half period equals divisor, then repeat
// [RL19] Run low floats all outputs
// [RL20] Float bit set keeps channel floating
// [RL21] Divisor zero acts as 256
// [RL22] Enable low clears every register; the code clears the register file, shifter and fetch flag but keeps sdo_r
// [RL23] Broadcast zero is daisy chain mode
// [RL24] Address map: delays, float bits, divisor
// [RL25] Chain output is shifter far end
// [RL26] Unknown addresses change nothing
package cwb_pkg;
	localparam int FRAME_BITS = 13;
	localparam int ADDR_BITS = 4;
	localparam int DATA_BITS = 8;
	localparam int NUM_CH = 8;
	localparam int WR_POS = 12;
	localparam int ADDR_LSB = 8;
	localparam logic [3:0] ADDR_FLOAT = 4'h8;
	localparam logic [3:0] ADDR_DIV = 4'h9;
	localparam logic [3:0] ADDR_CH_MAX = 4'h7;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int RUN_LATENCY = 2;
	localparam logic [8:0] DIV_ZERO_HALF = 9'h100;
	typedef enum logic [1:0] {CWB_IDLE, CWB_WAIT, CWB_COUNT, CWB_WAVE} cwb_ch_e;
endpackage : cwb_pkg

// >>> rtl/cwb_sync_if.sv
// Interface carrying synchronised serial pins to the serial engine
`timescale 1ns/10ps
interface cwb_sync_if;
	logic sel_low;
	logic sck;
	logic sdi;
	modport src (output sel_low, output sck, output sdi);
	modport dst (input sel_low, input sck, input sdi);
endinterface : cwb_sync_if

// >>> rtl/cwb_serial.sv
// Serial frame engine: shifter, register file, read fetch
`timescale 1ns/10ps
module cwb_serial
	import cwb_pkg::*;
(
	input wire logic clk, // Core clock
	input wire logic resetn, // Async reset, low
	input wire logic enable, // Synchronised enable
	input wire logic broadcast_select, // Synchronised mode
	cwb_sync_if.dst pins, // Synchronised serial pins
	output logic [NUM_CH*DATA_BITS-1:0] phase_delay_value, // Delays
	output logic [DATA_BITS-1:0] output_float_bits, // Float bits
	output logic [DATA_BITS-1:0] tone_freq_divisor, // Divisor
	output logic sdo_r // Serial out
);
	logic [FRAME_BITS-1:0] shift_r, shift_nxt;
	logic [DATA_BITS-1:0] regs_r [0:NUM_CH+1];
	logic [DATA_BITS-1:0] regs_nxt [0:NUM_CH+1];
	logic sck_d_r, sel_d_r, fetch_r, fetch_nxt, sdo_nxt;
	logic sck_rise, sel_rise;
	logic [ADDR_BITS-1:0] addr;

	assign sck_rise = pins.sck & ~sck_d_r;
	assign sel_rise = pins.sel_low & ~sel_d_r;
	assign addr = shift_r[WR_POS-1:ADDR_LSB];

	always_comb begin
		shift_nxt = shift_r;
		fetch_nxt = fetch_r;
		sdo_nxt = sdo_r;
		for (int i = 0; i < NUM_CH + 2; i++) begin
			regs_nxt[i] = regs_r[i];
		end
		if (!enable) begin
			for (int i = 0; i < NUM_CH + 2; i++) begin
				regs_nxt[i] = REG_RESET; // RL22
			end
			shift_nxt = '0;
			fetch_nxt = 1'b0;
		end else if (!pins.sel_low) begin
			if (sck_rise) begin
				shift_nxt = {shift_r[FRAME_BITS-2:0], pins.sdi}; // RL3 RL2
				sdo_nxt = shift_r[FRAME_BITS-1]; // RL25 RL11
			end
		end else if (sel_rise) begin
			if (shift_r[WR_POS]) begin
				if (addr <= ADDR_CH_MAX || addr == ADDR_FLOAT
						|| addr == ADDR_DIV) begin // RL24 RL26
					regs_nxt[addr] = shift_r[DATA_BITS-1:0]; // RL4 RL8 RL13
				end
			end else if (!broadcast_select) begin // RL12 RL23
				fetch_nxt = 1'b1; // RL9
			end
		end else if (fetch_r) begin
			fetch_nxt = 1'b0;
			shift_nxt = '0;
			if (addr <= ADDR_CH_MAX || addr == ADDR_FLOAT || addr == ADDR_DIV) begin
				shift_nxt[DATA_BITS-1:0] = regs_r[addr]; // RL10
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			shift_r <= '0;
			fetch_r <= 1'b0;
			sdo_r <= 1'b0;
			sck_d_r <= 1'b0;
			sel_d_r <= 1'b1;
			for (int i = 0; i < NUM_CH + 2; i++) begin
				regs_r[i] <= REG_RESET;
			end
		end else begin
			shift_r <= shift_nxt;
			fetch_r <= fetch_nxt;
			sdo_r <= sdo_nxt;
			sck_d_r <= pins.sck;
			sel_d_r <= pins.sel_low;
			for (int i = 0; i < NUM_CH + 2; i++) begin
				regs_r[i] <= regs_nxt[i];
			end
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			phase_delay_value[i*DATA_BITS +: DATA_BITS] = regs_r[i];
		end
		output_float_bits = regs_r[NUM_CH];
		tone_freq_divisor = regs_r[NUM_CH+1];
	end
endmodule : cwb_serial

// >>> tb/cwb_assertions.sv
// Port checker for the beamformer top
`timescale 1ns/10ps
module cwb_assertions
	import cwb_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic resetn, // Reset
	input wire logic enable, // Enable
	input wire logic select_low, // Select
	input wire logic sck, // Serial clock
	input wire logic sdi, // Data in
	input wire logic broadcast_select, // Mode
	input wire logic transmit_run, // Run
	input wire logic sdo, // Data out
	input wire logic [NUM_CH-1:0] wave_out, // Levels
	input wire logic [NUM_CH-1:0] wave_oe // Drives
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence run_held; transmit_run[*4]; endsequence
	sequence idle_held; (!transmit_run)[*4]; endsequence
	sequence chain_held; (!broadcast_select)[*7]; endsequence
	run_float_a: assert property (idle_held |-> wave_oe == 8'h00)
		else $error("channel drives while idle");
	oe_drop_a: assert property ((~wave_oe & $past(wave_oe)) != 8'h00
		|-> !$past(transmit_run)) else $error("channel dropped while run");
	start_pos_a: assert property ((wave_oe & ~$past(wave_oe)) != 8'h00
		|-> (wave_out & wave_oe & ~$past(wave_oe)) ==
		(wave_oe & ~$past(wave_oe))) else $error("wave starts negative");
	start_late_a: assert property ((wave_oe & ~$past(wave_oe)) != 8'h00
		|-> $past(transmit_run, 4)) else $error("wave starts too early");
	oe_steady_a: assert property (run_held ##0 wave_oe[0] |=> wave_oe[0])
		else $error("channel stopped while run");
	bcast_pass_a: assert property (broadcast_select[*5]
		|-> sdo == $past(sdi, 3)) else $error("broadcast not passed");
	sdo_hold_a: assert property ((!broadcast_select && select_low)[*6]
		|-> $stable(sdo)) else $error("serial out moved idle");
	sdo_on_sck_a: assert property (chain_held ##0 $changed(sdo)
		|-> $past(sck, 2) || $past(sck, 3)) else $error("sdo moved sans sck");
endmodule : cwb_assertions
bind cwb_top cwb_assertions cwb_assertions_i (.clk(clk), .resetn(resetn),
	.enable(enable), .select_low(select_low), .sck(sck), .sdi(sdi),
	.broadcast_select(broadcast_select), .transmit_run(transmit_run),
	.sdo(sdo), .wave_out(wave_out), .wave_oe(wave_oe));

// >>> tb/cwb_host.sv
// Serial master model standing in for the host
`timescale 1ns/10ps
module cwb_host (
	input wire logic clk, // Clock
	input wire logic sdo, // Reply
	output logic select_low, // Select
	output logic sck, // Serial clock
	output logic sdi // Data
);
	initial begin
		select_low = 1'b1;
		sck = 1'b0;
		sdi = 1'b1;
	end
	task automatic frame(input logic [12:0] f, output logic [12:0] rx);
		@(posedge clk) select_low <= 1'b0;
		for (int i = 12; i >= 0; i--) begin
			sdi <= f[i];
			repeat (5) @(posedge clk);
			sck <= 1'b1;
			repeat (5) @(posedge clk);
			sck <= 1'b0;
			rx = {rx[11:0], sdo};
		end
		repeat (5) @(posedge clk);
		select_low <= 1'b1;
		// Released line must not keep the last bit
		sdi <= ~f[0];
		repeat (24) @(posedge clk);
	endtask : frame
endmodule : cwb_host

// >>> tb/cwb_top_tb.sv
// Self-checking bench for the beamformer top
`timescale 1ns/10ps
module cwb_top_tb;
	import cwb_pkg::*;
	logic clk, resetn, enable, broadcast_select, transmit_run;
	logic select_low, sck, sdi, sdo;
	logic [NUM_CH-1:0] wave_out, wave_oe;
	logic [12:0] rx;
	int fail_count = 0, n_compared = 0, cyc = 0;
	cwb_top cwb_top_i (.clk(clk), .resetn(resetn), .enable(enable),
		.select_low(select_low), .sck(sck), .sdi(sdi),
		.broadcast_select(broadcast_select), .transmit_run(transmit_run),
		.sdo(sdo), .wave_out(wave_out), .wave_oe(wave_oe));
	cwb_host cwb_host_i (.clk(clk), .sdo(sdo), .select_low(select_low),
		.sck(sck), .sdi(sdi));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic tally_and_finish();
		if (fail_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick
	task automatic send(input logic [12:0] f);
		cwb_host_i.frame(f, rx);
	endtask : send
	// A read needs a second frame to shift the fetched byte out
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		send({1'b0, a, 8'h00});
		send(13'h0000);
		chk(rx, {5'h00, exp});
	endtask : rd
	task automatic wait_oe(output int n);
		for (n = 0; n < 400 && wave_oe[0] !== 1'b1; n++)
			tick();
	endtask : wait_oe
	task automatic t_regs();
		send(13'h1355);
		send(13'h1aff);
		rd(4'h3, 8'h55);
		rd(4'h2, 8'h00);
		rd(4'ha, 8'h00);
	endtask : t_regs
	task automatic t_bcast();
		@(posedge clk) broadcast_select <= 1'b1;
		send(13'h13aa);
		send(13'h0300);
		@(posedge clk) broadcast_select <= 1'b0;
		repeat (8) @(posedge clk);
		send(13'h0000);
		chk(rx, 13'h0300);
		rd(4'h3, 8'haa);
	endtask : t_bcast
	task automatic t_wave();
		int w;
		send(13'h1002);
		send(13'h1103);
		send(13'h18fc);
		send(13'h1904);
		@(posedge clk) transmit_run <= 1'b1;
		wait_oe(w);
		// Two sync stages, start latency, delay of two, output flop
		chk(13'(w), 13'(RUN_LATENCY + 5));
		chk(13'({wave_oe, wave_out[0]}), 13'h003);
		tick();
		chk(13'(wave_oe), 13'h003);
		repeat (2) tick();
		chk(13'(wave_out[0]), 13'h001);
		tick();
		chk(13'(wave_out[0]), 13'h000);
		@(posedge clk) transmit_run <= 1'b0;
		repeat (5) tick();
		chk(13'(wave_oe), 13'h000);
		rd(4'h8, 8'hfc);
		rd(4'h9, 8'h04);
	endtask : t_wave
	task automatic t_div0();
		int n = 0;
		int w;
		send(13'h1900);
		@(posedge clk) transmit_run <= 1'b1;
		wait_oe(w);
		chk(13'(w), 13'(RUN_LATENCY + 5));
		while (wave_out[0] === 1'b1 && n < 300) begin
			tick();
			n++;
		end
		chk(13'(n), 13'h100);
		@(posedge clk) transmit_run <= 1'b0;
		repeat (5) tick();
	endtask : t_div0
	task automatic t_enable();
		@(posedge clk) enable <= 1'b0;
		repeat (8) @(posedge clk);
		enable <= 1'b1;
		repeat (8) @(posedge clk);
		rd(4'h3, 8'h00);
	endtask : t_enable
	initial begin
		resetn = 1'b0;
		enable = 1'b1;
		broadcast_select = 1'b0;
		transmit_run = 1'b0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		t_regs();
		t_bcast();
		t_wave();
		t_div0();
		t_enable();
		tally_and_finish();
	end
endmodule : cwb_top_tb
